// *** verilog/fsed_pkg.sv ***
/*
  Package for the frame start and end detector: register offsets, field
  positions, reset values, modes and the host register map shared by both ends.
  Assumes nothing of its surroundings.
*/
package fsed_pkg;
  // ----------------------------------------------------------------------
  // Register offsets, configuration A and B
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFGA_BASE = 8'h82;
  localparam logic [7:0] CFGB_BASE = 8'hA2;
  localparam logic [7:0] CFGA_START_PATTERN_MODE = 8'h82;
  localparam logic [7:0] CFGA_PATTERN_A_LENGTH = 8'h83;
  localparam logic [7:0] CFGA_PATTERN_B_LENGTH = 8'h84;
  localparam logic [7:0] CFGA_PATTERN_A_LOW = 8'h86;
  localparam logic [7:0] CFGA_PATTERN_A_HIGH = 8'h87;
  localparam logic [7:0] CFGA_PATTERN_B_LOW = 8'h88;
  localparam logic [7:0] CFGA_PATTERN_B_HIGH = 8'h89;
  localparam logic [7:0] CFGA_END_DETECT_CTRL = 8'h8A;
  localparam logic [7:0] CFGA_END_LENGTH_LIMIT = 8'h8B;
  localparam logic [7:0] CFGB_START_PATTERN_MODE = 8'hA2;
  localparam logic [7:0] CFGB_PATTERN_A_LENGTH = 8'hA3;
  localparam logic [7:0] CFGB_PATTERN_B_LENGTH = 8'hA4;
  localparam logic [7:0] CFGB_PATTERN_A_LOW = 8'hA6;
  localparam logic [7:0] CFGB_PATTERN_A_HIGH = 8'hA7;
  localparam logic [7:0] CFGB_PATTERN_B_LOW = 8'hA8;
  localparam logic [7:0] CFGB_PATTERN_B_HIGH = 8'hA9;
  localparam logic [7:0] CFGB_END_DETECT_CTRL = 8'hAA;
  localparam logic [7:0] CFGB_END_LENGTH_LIMIT = 8'hAB;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GAP_RESYNC_SELECT_BIT = 7;
  localparam int WILDCARD_HI = 6;
  localparam int WILDCARD_LO = 3;
  localparam int PHASE_READJUST_BIT = 2;
  localparam int MODE_SEL_HI = 1;
  localparam int MODE_SEL_LO = 0;
  localparam int END_ON_SYNC_LOSS_BIT = 2;
  localparam int END_ON_CODE_VIOLATION_BIT = 1;
  localparam int END_ON_LENGTH_BIT = 0;
  localparam int END_CTRL_UNUSED_BIT = 3;
  localparam int LEN_HI = 4;
  localparam logic [4:0] LEN_MAX = 5'h10;

  // ----------------------------------------------------------------------
  // Correlator modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_16BIT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_GAP = 2'h2;
  localparam logic [1:0] MODE_8BIT_EXT = 2'h3;

  // ----------------------------------------------------------------------
  // AXI4-Lite register map of the host controller
  // ----------------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_VALID_BIT = 16;
endpackage

// *** verilog/fsed_link_if.sv ***
/*
  Link between the host configuration end and the detector end.
  Carries single-cycle register writes and the bank select from host to detector.
*/
`timescale 1ns/1ps
interface fsed_link_if;
  logic cfg_wr;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_data;
  logic cfg_sel_b;

  modport host
  (
    output cfg_wr,
    output cfg_addr,
    output cfg_data,
    output cfg_sel_b
  );
  modport device
  (
    input cfg_wr,
    input cfg_addr,
    input cfg_data,
    input cfg_sel_b
  );
endinterface

// *** verilog/fsed_sync3.sv ***
/*
  Three-stage input conditioner for pins outside the clock domain.
  A change counts once stages two and three agree.
*/
`timescale 1ns/1ps
module fsed_sync3
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed
  {
    logic [2:0] sh;
    logic lvl;
  } fsed_sync_t;

  fsed_sync_t s_q;
  fsed_sync_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], pin_in};
    if (s_q.sh[1] == s_q.sh[2])
    begin
      s_d.lvl = s_q.sh[2];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.lvl;
endmodule

// *** verilog/fsed_detector.sv ***
/*
  Frame start correlators and end-of-message detector.
  Assumes the chip stream, chip strobe, symbol sync and code violation
  flag come from upstream symbol sync logic as pins; configuration
  arrives over the link from the host end.
*/
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fsed_detector
#(
  parameter int VIOLATION_WINDOW = 8
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Configuration link
  fsed_link_if.device link,
  // Upstream chip stream
  input wire logic chip_in,
  input wire logic chip_stb_in,
  input wire logic symbol_sync_in,
  input wire logic manchester_code_violation_in,
  // Frame outputs
  output logic frame_sync_found_out,
  output logic end_of_message_out,
  output logic payload_bit_out,
  output logic payload_stb_out,
  output logic gap_resync_out,
  output logic phase_readjust_out,
  output logic sync_hold_out
);
  initial
  begin
    if (VIOLATION_WINDOW < 1 || VIOLATION_WINDOW > 255)
      $error("VIOLATION_WINDOW out of range");
  end

  typedef enum {ST_SEARCH, ST_PAYLOAD} fsed_state_t;
  typedef logic [7:0] fsed_cfg_t [18];

  typedef struct packed
  {
    fsed_state_t st;
    logic [7:0] mode;
    logic [4:0] len_a;
    logic [4:0] len_b;
    logic [15:0] pat_a;
    logic [15:0] pat_b;
    logic [2:0] end_ctrl;
    logic [7:0] limit;
    logic [31:0] hist;
    logic [8:0] bits;
    logic half;
    logic [7:0] hold;
    logic sync_prev;
    logic frame_sync_found;
    logic end_of_message;
    logic pbit;
    logic pstb;
  } fsed_state_s_t;

  fsed_state_s_t r_q;
  fsed_state_s_t r_d;
  logic [7:0] cfg_a_q [10];
  logic [7:0] cfg_b_q [10];
  logic chip_s;
  logic stb_s;
  logic sync_s;
  logic cv_s;
  logic [31:0] mask_a;
  logic [31:0] mask_b;
  logic hit_a;
  logic hit_b;

  fsed_sync3 u_chip (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pin_in(chip_in), .level_out(chip_s));
  fsed_sync3 u_stb (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pin_in(chip_stb_in), .level_out(stb_s));
  fsed_sync3 u_sync (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pin_in(symbol_sync_in), .level_out(sync_s));
  fsed_sync3 u_cv (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pin_in(manchester_code_violation_in), .level_out(cv_s));

  // ----------------------------------------------------------------------
  // Dual configuration banks
  // ----------------------------------------------------------------------
  logic stb_prev_q;
  logic chip_tick;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 10; i++)
      begin
        cfg_a_q[i] <= fsed_pkg::CFG_RESET;
        cfg_b_q[i] <= fsed_pkg::CFG_RESET;
      end
      stb_prev_q <= 1'b0;
    end
    else
    begin
      stb_prev_q <= stb_s;
      if (link.cfg_wr && link.cfg_addr >= fsed_pkg::CFGA_START_PATTERN_MODE
          && link.cfg_addr <= fsed_pkg::CFGA_END_LENGTH_LIMIT)
        cfg_a_q[4'(link.cfg_addr - fsed_pkg::CFGA_BASE)] <= link.cfg_data;
      if (link.cfg_wr && link.cfg_addr >= fsed_pkg::CFGB_START_PATTERN_MODE
          && link.cfg_addr <= fsed_pkg::CFGB_END_LENGTH_LIMIT)
        cfg_b_q[4'(link.cfg_addr - fsed_pkg::CFGB_BASE)] <= link.cfg_data;
    end
  end

  assign chip_tick = stb_s && !stb_prev_q;

  // ----------------------------------------------------------------------
  // Correlator masks
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_mask
      // Wild cards free the oldest four chips of pattern A
      assign mask_a[gi] = (gi < r_q.len_a) &&
        !(gi >= 12 && r_q.mode[fsed_pkg::WILDCARD_LO + (gi % 4)]);
      assign mask_b[gi] = gi < r_q.len_b;
      assign mask_a[gi + 16] = 1'b0;
      assign mask_b[gi + 16] = 1'b0;
    end
  endgenerate

  always_comb
  begin
    hit_a = ((r_q.hist[15:0] ^ r_q.pat_a) & mask_a[15:0]) == 16'h0000;
    hit_b = ((r_q.hist[15:0] ^ r_q.pat_b) & mask_b[15:0]) == 16'h0000;
    if (r_q.mode[fsed_pkg::MODE_SEL_HI:fsed_pkg::MODE_SEL_LO]
        == fsed_pkg::MODE_16BIT)
    begin
      // B chained ahead of A forms a 32-chip correlator
      hit_a = hit_a && (((r_q.hist[31:16] ^ r_q.pat_b) & mask_b[15:0])
        == 16'h0000);
      hit_b = 1'b0;
    end
    else if (r_q.len_a == 5'h00)
      hit_a = 1'b0;
    if (r_q.len_b == 5'h00)
      hit_b = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Frame and end-of-message sequencing
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] c [10];
    logic lost;
    logic len_done;
    c = link.cfg_sel_b ? cfg_b_q : cfg_a_q;
    lost = r_q.hold == 8'h01 && !sync_s;
    len_done = 1'b0;
    r_d = r_q;
    r_d.mode = c[0];
    r_d.len_a = (c[1][4:0] > fsed_pkg::LEN_MAX) ? fsed_pkg::LEN_MAX
      : c[1][4:0];
    r_d.len_b = (c[2][4:0] > fsed_pkg::LEN_MAX) ? fsed_pkg::LEN_MAX
      : c[2][4:0];
    r_d.pat_a = {c[5], c[4]};
    r_d.pat_b = {c[7], c[6]};
    r_d.end_ctrl = c[8][2:0];
    r_d.limit = c[9];
    r_d.frame_sync_found = 1'b0;
    r_d.end_of_message = 1'b0;
    r_d.pstb = 1'b0;
    r_d.sync_prev = sync_s;
    // Sync indication lingers after symbol sync drops
    if (sync_s)
      r_d.hold = 8'(VIOLATION_WINDOW);
    else if (r_q.hold != 8'h00)
      r_d.hold = r_q.hold - 8'h01;
    case (r_q.st)
      ST_SEARCH:
      begin
        if (chip_tick)
          r_d.hist = {r_q.hist[30:0], chip_s};
        if ((hit_a || hit_b || (r_q.len_a == 5'h00 && r_q.len_b == 5'h00
            && r_q.mode[1:0] == fsed_pkg::MODE_16BIT && sync_s))
            && r_q.hold != 8'h00)
        begin
          r_d.frame_sync_found = 1'b1;
          r_d.st = ST_PAYLOAD;
          r_d.bits = 9'h000;
          r_d.half = 1'b0;
          r_d.hist = '0;
          if (r_q.mode[1:0] == fsed_pkg::MODE_8BIT_EXT)
          begin
            r_d.pbit = !hit_a;
            r_d.pstb = 1'b1;
          end
        end
      end
      ST_PAYLOAD:
      begin
        if (chip_tick)
        begin
          r_d.half = !r_q.half;
          if (r_q.half) // Second chip of a bit
          begin
            r_d.pbit = chip_s;
            r_d.pstb = 1'b1;
            r_d.bits = r_q.bits + 9'h001;
            // Limit zero fires on the first bit
            len_done = r_q.bits[7:0] == r_q.limit && !r_q.bits[8];
          end
        end
        if ((r_q.end_ctrl[fsed_pkg::END_ON_LENGTH_BIT] && len_done) ||
            (r_q.end_ctrl[fsed_pkg::END_ON_CODE_VIOLATION_BIT] && cv_s) ||
            (r_q.end_ctrl[fsed_pkg::END_ON_SYNC_LOSS_BIT] && lost))
        begin
          r_d.end_of_message = 1'b1;
          r_d.st = ST_SEARCH;
        end
        else if (r_q.hold == 8'h00)
          r_d.st = ST_SEARCH;
      end
      default:
        r_d.st = ST_SEARCH;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r_q <= '0;
      r_q.st <= ST_SEARCH;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign frame_sync_found_out = r_q.frame_sync_found;
  assign end_of_message_out = r_q.end_of_message;
  assign payload_bit_out = r_q.pbit;
  assign payload_stb_out = r_q.pstb;
  assign gap_resync_out = r_q.mode[fsed_pkg::GAP_RESYNC_SELECT_BIT];
  assign phase_readjust_out = r_q.mode[fsed_pkg::PHASE_READJUST_BIT];
  assign sync_hold_out = r_q.hold != 8'h00;
endmodule

// *** verilog/fsed_host.sv ***
/*
  Host end: AXI4-Lite slave that turns register commands into single
  configuration writes on the link.
  Assumes a conforming AXI4-Lite master on the same clock.
*/
`timescale 1ns/1ps
module fsed_host
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Link
  fsed_link_if.host link
);
  typedef struct packed
  {
    logic aw_have;
    logic [7:0] aw;
    logic w_have;
    logic [31:0] w;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic sel_b;
    logic [7:0] count;
  } fsed_host_t;

  fsed_host_t h_q;
  fsed_host_t h_d;

  always_comb
  begin
    logic [7:0] a;
    logic wok;
    a = h_q.w[15:8];
    wok = 1'b0;
    h_d = h_q;
    h_d.wr = 1'b0;
    if (s_axi_awvalid_in && !h_q.aw_have && !h_q.bvalid)
    begin
      h_d.aw_have = 1'b1;
      h_d.aw = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !h_q.w_have && !h_q.bvalid)
    begin
      h_d.w_have = 1'b1;
      h_d.w = s_axi_wdata_in;
    end
    if (h_q.aw_have && h_q.w_have)
    begin
      h_d.aw_have = 1'b0;
      h_d.w_have = 1'b0;
      h_d.bvalid = 1'b1;
      h_d.bresp = fsed_pkg::RESP_SLVERR;
      if (h_q.aw == fsed_pkg::HOST_CMD)
      begin
        h_d.bresp = fsed_pkg::RESP_OKAY;
        h_d.sel_b = h_q.w[fsed_pkg::CMD_VALID_BIT + 1];
        wok = h_q.w[fsed_pkg::CMD_VALID_BIT];
        // Unused end control bit forced low
        if (a == fsed_pkg::CFGA_END_DETECT_CTRL ||
            a == fsed_pkg::CFGB_END_DETECT_CTRL)
          h_d.data = h_q.w[7:0] & 8'hF7;
        else if (a == fsed_pkg::CFGA_PATTERN_A_LENGTH ||
            a == fsed_pkg::CFGA_PATTERN_B_LENGTH ||
            a == fsed_pkg::CFGB_PATTERN_A_LENGTH ||
            a == fsed_pkg::CFGB_PATTERN_B_LENGTH)
          h_d.data = (h_q.w[4:0] > fsed_pkg::LEN_MAX) ?
            {3'h0, fsed_pkg::LEN_MAX} :
            {3'h0, h_q.w[4:0]};
        else
          h_d.data = h_q.w[7:0];
        // Only addresses inside either bank reach the link
        h_d.wr = wok && ((a >= fsed_pkg::CFGA_START_PATTERN_MODE &&
          a <= fsed_pkg::CFGA_END_LENGTH_LIMIT) ||
          (a >= fsed_pkg::CFGB_START_PATTERN_MODE &&
          a <= fsed_pkg::CFGB_END_LENGTH_LIMIT));
        h_d.addr = a;
        if (wok)
          h_d.count = h_q.count + 8'h01;
      end
    end
    if (h_q.bvalid && s_axi_bready_in)
      h_d.bvalid = 1'b0;
    if (s_axi_arvalid_in && !h_q.rvalid)
    begin
      h_d.rvalid = 1'b1;
      h_d.rresp = fsed_pkg::RESP_OKAY;
      h_d.rdata = 32'h0000_0000;
      if (s_axi_araddr_in == fsed_pkg::HOST_STATUS)
        h_d.rdata = {23'h000000, h_q.sel_b, h_q.count};
      else if (s_axi_araddr_in == fsed_pkg::HOST_CMD)
        h_d.rdata = h_q.w;
      else
        h_d.rresp = fsed_pkg::RESP_SLVERR;
    end
    else if (h_q.rvalid && s_axi_rready_in)
      h_d.rvalid = 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      h_q <= '0;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  assign s_axi_awready_out = !h_q.aw_have && !h_q.bvalid;
  assign s_axi_wready_out = !h_q.w_have && !h_q.bvalid;
  assign s_axi_bvalid_out = h_q.bvalid;
  assign s_axi_bresp_out = h_q.bresp;
  assign s_axi_arready_out = !h_q.rvalid;
  assign s_axi_rvalid_out = h_q.rvalid;
  assign s_axi_rdata_out = h_q.rdata;
  assign s_axi_rresp_out = h_q.rresp;
  assign link.cfg_wr = h_q.wr;
  assign link.cfg_addr = h_q.addr;
  assign link.cfg_data = h_q.data;
  assign link.cfg_sel_b = h_q.sel_b;
endmodule

// *** sim/fsed_props.sv ***
/*
  Checker for the configuration link between host end and detector end.
  Assumes it is instantiated beside the link interface, on the same clock.
*/
`timescale 1ns/1ps
module fsed_props
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Link signals
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic cfg_sel_b
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence s_len_a_wr;
    cfg_wr && (cfg_addr == fsed_pkg::CFGA_PATTERN_A_LENGTH ||
      cfg_addr == fsed_pkg::CFGB_PATTERN_A_LENGTH);
  endsequence
  sequence s_len_b_wr;
    cfg_wr && (cfg_addr == fsed_pkg::CFGA_PATTERN_B_LENGTH ||
      cfg_addr == fsed_pkg::CFGB_PATTERN_B_LENGTH);
  endsequence
  sequence s_ctrl_wr;
    cfg_wr && (cfg_addr == fsed_pkg::CFGA_END_DETECT_CTRL ||
      cfg_addr == fsed_pkg::CFGB_END_DETECT_CTRL);
  endsequence
  sequence s_gap2;
    !cfg_wr [*2];
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_len_a_max;
    s_len_a_wr |-> cfg_data <= 8'h10;
  endproperty
  property p_len_b_max;
    s_len_b_wr |-> cfg_data <= 8'h10;
  endproperty
  property p_ctrl_bit3;
    s_ctrl_wr |-> cfg_data[3] == 1'b0;
  endproperty
  property p_range_top;
    cfg_wr |-> cfg_addr[7:4] == 4'h8 || cfg_addr[7:4] == 4'hA;
  endproperty
  property p_range_a;
    cfg_wr && cfg_addr[7:4] == 4'h8 |->
      cfg_addr[3:0] >= 4'h2 && cfg_addr[3:0] <= 4'hB;
  endproperty
  property p_range_b;
    cfg_wr && cfg_addr[7:4] == 4'hA |->
      cfg_addr[3:0] >= 4'h2 && cfg_addr[3:0] <= 4'hB;
  endproperty
  property p_wr_spacing;
    cfg_wr |=> s_gap2;
  endproperty
  property p_quiet_after_reset;
    $rose(rst_n_in) |-> s_gap2;
  endproperty

  a_len_a_max: assert property (p_len_a_max)
    else $error("correlator A length above sixteen");
  a_len_b_max: assert property (p_len_b_max)
    else $error("correlator B length above sixteen");
  a_ctrl_bit3: assert property (p_ctrl_bit3)
    else $error("end control unused bit written as one");
  a_range_top: assert property (p_range_top)
    else $error("link write outside both banks");
  a_range_a: assert property (p_range_a)
    else $error("link write outside bank A range");
  a_range_b: assert property (p_range_b)
    else $error("link write outside bank B range");
  a_wr_spacing: assert property (p_wr_spacing)
    else $error("link writes closer than three cycles");
  a_quiet_after_reset: assert property (p_quiet_after_reset)
    else $error("link write right after reset");
endmodule

// *** sim/frame_start_and_end_detector_test.sv ***
/*
  Testbench: host end and detector end joined by the link interface.
  Drives AXI4-Lite and the upstream chip pins, counts frame outputs.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module frame_start_and_end_detector_test;
  localparam logic [15:0] PAT = 16'h2BD4;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic chip = 1'b0, stb = 1'b0, sync = 1'b0, cv = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire frame_sync_found, end_of_message, pbit, pstb, gap, phase, hold;
  int mismatches = 0, num_checks = 0, cyc = 0, n_fs = 0, n_eom = 0;
  int n_pb = 0, n_one = 0, ext = 0;
  logic [7:0] nwr = 8'h00;
  logic [7:0] base = fsed_pkg::CFGA_BASE;
  logic selb = 1'b0;
  logic [31:0] d;
  logic [1:0] r;

  // ----------------------------------------------------------------------
  // Design, link and checker
  // ----------------------------------------------------------------------
  fsed_link_if u_fsed_link_if();
  fsed_host u_fsed_host
  (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .link(u_fsed_link_if)
  );
  fsed_detector #(.VIOLATION_WINDOW(4)) u_fsed_detector
  (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(u_fsed_link_if),
    .chip_in(chip), .chip_stb_in(stb), .symbol_sync_in(sync),
    .manchester_code_violation_in(cv), .frame_sync_found_out(frame_sync_found),
    .end_of_message_out(end_of_message), .payload_bit_out(pbit),
    .payload_stb_out(pstb), .gap_resync_out(gap),
    .phase_readjust_out(phase), .sync_hold_out(hold)
  );
  fsed_props u_fsed_props
  (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cfg_wr(u_fsed_link_if.cfg_wr), .cfg_addr(u_fsed_link_if.cfg_addr),
    .cfg_data(u_fsed_link_if.cfg_data),
    .cfg_sel_b(u_fsed_link_if.cfg_sel_b)
  );

  // ----------------------------------------------------------------------
  // Clock, event counters, timeout
  // ----------------------------------------------------------------------
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (frame_sync_found === 1'b1) n_fs++;
    if (end_of_message === 1'b1) n_eom++;
    if (pstb === 1'b1) n_pb++;
    if (pstb === 1'b1 && pbit === 1'b1) n_one++;
    if (cyc == 30000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task test_done;
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] rs);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge ref_clk_in);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_in); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk_in); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task dev_wr(input logic [7:0] a, input logic [7:0] v);
    axi_wr(fsed_pkg::HOST_CMD, {14'h0000, selb, 1'b1, a, v}, r);
    nwr = nwr + 8'h01;
    `CHK(r, fsed_pkg::RESP_OKAY)
  endtask
  task send_chip(input logic c);
    chip <= c;
    repeat (4) @(posedge ref_clk_in);
    stb <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    stb <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  // Action 1 raises a code violation, 2 drops symbol sync
  task run_frame(input logic [7:0] ctrl, input logic [7:0] lim,
    input int nb, input int act, input int exp);
    int i;
    int m;
    dev_wr(base + 8'h08, ctrl);
    dev_wr(base + 8'h09, lim);
    n_fs = 0;
    n_eom = 0;
    n_pb = 0;
    n_one = 0;
    sync <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    for (i = 0; i < 4; i++) send_chip(1'b0);
    for (i = 15; i >= 0; i--) send_chip(PAT[i]);
    for (i = 0; i < 2 * nb; i++) send_chip(i[0] ^ i[1]);
    if (act == 1)
    begin
      cv <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      cv <= 1'b0;
    end
    if (act == 2)
    begin
      sync <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
      `CHK(hold, 1'b1)
      repeat (20) @(posedge ref_clk_in);
      `CHK(hold, 1'b0)
    end
    repeat (10) @(posedge ref_clk_in);
    `CHK(n_fs, 1)
    `CHK(n_eom, exp)
    // Bits delivered stop at the length end, payload bits alternate 1, 0
    m = (ctrl[0] && lim < nb) ? lim + 1 : nb;
    `CHK(n_pb, m + ext)
    `CHK(n_one, (m + 1) / 2)
    sync <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    axi_rd(fsed_pkg::HOST_STATUS, d, r);
    `CHK(d[8:0], 9'h000)
    axi_rd(8'h08, d, r);
    `CHK(r, fsed_pkg::RESP_SLVERR)
    `CHK(d, 32'h00000000)
    axi_wr(8'h0C, 32'h00000000, r);
    `CHK(r, fsed_pkg::RESP_SLVERR)
    dev_wr(8'h90, 8'h55);
    `CHK({gap, phase}, 2'h0)
    for (int b = 0; b < 2; b++)
    begin
      base = (b == 0) ? fsed_pkg::CFGA_BASE : fsed_pkg::CFGB_BASE;
      dev_wr(base, (b == 0) ? 8'h80 : 8'h04);
      dev_wr(base + 8'h01, (b == 0) ? 8'h10 : 8'h1F);
      dev_wr(base + 8'h02, 8'h00);
      dev_wr(base + 8'h04, PAT[7:0]);
      dev_wr(base + 8'h05, PAT[15:8]);
    end
    base = fsed_pkg::CFGA_BASE;
    repeat (4) @(posedge ref_clk_in);
    `CHK({gap, phase}, 2'h2)
    run_frame(8'h01, 8'h00, 0, 0, 0);
    run_frame(8'h01, 8'h00, 1, 0, 1);
    run_frame(8'h01, 8'h03, 3, 0, 0);
    run_frame(8'h01, 8'h03, 3, 0, 0);
    run_frame(8'h01, 8'h03, 4, 0, 1);
    run_frame(8'h02, 8'hFF, 2, 1, 1);
    run_frame(8'h01, 8'hFF, 2, 1, 0);
    run_frame(8'h04, 8'hFF, 1, 2, 1);
    run_frame(8'h02, 8'hFF, 1, 2, 0);
    run_frame(8'h07, 8'hFF, 1, 1, 1);
    run_frame(8'h07, 8'h02, 3, 0, 1);
    dev_wr(base, 8'hF8);
    dev_wr(base + 8'h05, PAT[15:8] ^ 8'hF0);
    run_frame(8'h01, 8'h00, 1, 0, 1);
    dev_wr(base + 8'h05, PAT[15:8]);
    dev_wr(base, 8'h03);
    ext = 1;
    run_frame(8'h01, 8'h01, 2, 0, 1);
    ext = 0;
    dev_wr(base, 8'h80);
    selb = 1'b1;
    axi_wr(fsed_pkg::HOST_CMD, 32'h00020000, r);
    `CHK(r, fsed_pkg::RESP_OKAY)
    base = fsed_pkg::CFGB_BASE;
    repeat (4) @(posedge ref_clk_in);
    `CHK({gap, phase}, 2'h1)
    run_frame(8'h09, 8'h01, 2, 0, 1);
    axi_rd(fsed_pkg::HOST_STATUS, d, r);
    `CHK(d[8:0], {1'b1, nwr})
    test_done();
  end
endmodule
